// ==== rtl/oag_defs.svh ====
// constants for the operand address generator
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH
`define OAG_AW 24
`define OAG_CONST_MSB 15
`define OAG_PAGE_MSB 7
`define OAG_DISP_MSB 7
`define OAG_PSEL_LSB 8
`define OAG_PSEL_MSB 10
`define OAG_MODE_LSB 11
`define OAG_MODE_MSB 15
`define OAG_GRP_DISP 2'h0
`define OAG_GRP_IR0 2'h1
`define OAG_GRP_IR1 2'h2
`define OAG_KIND_PRE 2'h0
`define OAG_KIND_PREWB 2'h1
`define OAG_KIND_POST 2'h2
`define OAG_KIND_CIRC 2'h3
`define OAG_MODE_PLAIN 5'h18
`define OAG_DISP_ONE 24'h000001
`define OAG_SEL_DP 5'h08
`define OAG_SEL_IR0 5'h09
`define OAG_SEL_IR1 5'h0A
`define OAG_SEL_BK 5'h0B
`define OAG_RST_REG 32'h0000_0000
`endif

// ==== rtl/oag_pkg.sv ====
// types and shared arithmetic of the operand address generator
package oag_pkg;

  // one instruction handed over by the decoder
  typedef struct packed {
    logic        direct;
    logic        disp_given;
    logic [31:0] instr;
  } oag_req_t;

  // register file write into the address unit
  typedef struct packed {
    logic        en;
    logic [4:0]  sel;
    logic [31:0] data;
  } oag_rf_wr_t;

  // pointer write-back reported to the register file
  typedef struct packed {
    logic        valid;
    logic [2:0]  sel;
    logic [31:0] data;
  } oag_wb_t;

  // unsigned 24-bit add or subtract, wraps modulo 2^24
  function automatic logic [23:0] oag_addsub(
    input logic [23:0] a, input logic [23:0] b, input logic sub);
    oag_addsub = sub ? 24'(a - b) : 24'(a + b);
  endfunction : oag_addsub

  // all ones from the top set bit downward
  function automatic logic [23:0] oag_smear(input logic [23:0] v);
    logic [23:0] m;
    m = v;
    for (int i = 1; i < 24; i = i * 2) begin
      m = m | (m >> i);
    end
    oag_smear = m;
  endfunction : oag_smear

endpackage : oag_pkg

// ==== rtl/oag_circ.sv ====
// circular modify of a pointer inside an aligned buffer
`timescale 1ns/10ps
`default_nettype none
module oag_circ (
  // operands
  input  wire logic [23:0] ptr,
  input  wire logic [23:0] step,
  input  wire logic [23:0] len,
  input  wire logic        sub,
  // wrapped result
  output logic      [23:0] res
);
  logic [23:0] mask;
  logic [23:0] base;
  logic [23:0] idx;
  logic [24:0] up;
  logic [24:0] dn;
  logic [23:0] off;
  logic        lin;

  // buffer sits on the power of two above its length
  assign mask = oag_pkg::oag_smear(len);
  assign base = ptr & ~mask;
  assign idx  = ptr & mask;
  assign lin  = (len == 24'h000000);
  // offset inside buffer after one wrap at most
  assign up   = {1'b0, idx} + {1'b0, step};
  assign dn   = {1'b0, idx} + {1'b0, len} - {1'b0, step};
  assign off  = sub ? ((idx >= step) ? 24'(idx - step) : dn[23:0])
                    : ((up >= {1'b0, len}) ? 24'(up - {1'b0, len})
                                           : up[23:0]);
  // zero length falls back to linear arithmetic
  assign res  = lin ? oag_pkg::oag_addsub(ptr, step, sub)
                    : (base | (off & mask));
endmodule : oag_circ
`default_nettype wire

// ==== rtl/oag_top.sv ====
// operand address generator: direct and indirect address forming
`timescale 1ns/10ps
`default_nettype none
`include "oag_defs.svh"
module oag_top (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  // instruction from the decoder
  input  wire logic               req_valid,
  input  wire oag_pkg::oag_req_t  req,
  // register file writes
  input  wire oag_pkg::oag_rf_wr_t rf_wr,
  // operand address to data memory
  output logic                    addr_valid,
  output logic      [23:0]        data_addr,
  output logic                    mode_reserved,
  // pointer write-back to register file
  output oag_pkg::oag_wb_t        wb
);

  // address unit registers
  logic [31:0] ptr_reg [8];
  logic [31:0] data_page_pointer;
  logic [31:0] index_reg_zero;
  logic [31:0] index_reg_one;
  logic [31:0] buffer_length_register;

  // instruction fields
  logic [4:0]  mode;
  logic [2:0]  psel;
  logic [1:0]  grp;
  logic [1:0]  kind;
  logic        sub;
  logic [7:0]  disp;

  assign mode = req.instr[`OAG_MODE_MSB:`OAG_MODE_LSB];
  assign psel = req.instr[`OAG_PSEL_MSB:`OAG_PSEL_LSB];
  assign disp = req.instr[`OAG_DISP_MSB:0];
  assign grp  = mode[4:3];
  assign kind = mode[2:1];
  assign sub  = mode[0];

  // operand selection
  logic [31:0] ptr_cur;
  logic [23:0] ptr_lo;
  logic [23:0] step;
  logic [23:0] disp_step;

  assign ptr_cur   = ptr_reg[psel];
  assign ptr_lo    = ptr_cur[23:0];
  assign disp_step = req.disp_given ? {16'h0000, disp}
                                    : `OAG_DISP_ONE;
  assign step = (grp == `OAG_GRP_DISP) ? disp_step
              : (grp == `OAG_GRP_IR0)  ? index_reg_zero[23:0]
              : index_reg_one[23:0];

  // mode class decode
  logic spec;
  logic plain;
  logic rsvd;
  logic pre;
  logic wb_en;

  assign spec  = (grp == 2'h3);
  assign plain = (mode == `OAG_MODE_PLAIN);
  assign rsvd  = spec && !plain;
  assign pre   = (kind == `OAG_KIND_PRE) || (kind == `OAG_KIND_PREWB);
  assign wb_en = !spec && (kind != `OAG_KIND_PRE);

  // linear and circular pointer arithmetic
  logic [23:0] lin_sum;
  logic [23:0] circ_sum;

  assign lin_sum = oag_pkg::oag_addsub(ptr_lo, step, sub);

  oag_circ u_circ (
    .ptr  (ptr_lo),
    .step (step),
    .len  (buffer_length_register[23:0]),
    .sub  (sub),
    .res  (circ_sum)
  );

  // address and write-back values
  logic [23:0] next_addr;
  logic [23:0] wb_lo;
  logic [31:0] next_ptr;
  logic        do_wb;

  // pre modes address the sum, post and plain use the pointer
  assign next_addr = req.direct
                   ? {data_page_pointer[`OAG_PAGE_MSB:0],
                      req.instr[`OAG_CONST_MSB:0]}
                   : (!spec && pre) ? lin_sum
                   : ptr_lo;
  assign wb_lo    = (kind == `OAG_KIND_CIRC) ? circ_sum
                  : lin_sum;
  assign next_ptr = {ptr_cur[31:24], wb_lo};
  assign do_wb    = req_valid && !req.direct && wb_en;

  // pointer registers: register file write wins over write-back
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        ptr_reg[i] <= `OAG_RST_REG;
      end
    end else begin
      if (do_wb) begin
        ptr_reg[psel] <= next_ptr;
      end
      if (rf_wr.en && !rf_wr.sel[4] && !rf_wr.sel[3]) begin
        ptr_reg[rf_wr.sel[2:0]] <= rf_wr.data;
      end
    end
  end

  // page, index and length registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_page_pointer      <= `OAG_RST_REG;
      index_reg_zero         <= `OAG_RST_REG;
      index_reg_one          <= `OAG_RST_REG;
      buffer_length_register <= `OAG_RST_REG;
    end else if (rf_wr.en) begin
      case (rf_wr.sel)
        `OAG_SEL_DP:  data_page_pointer      <= rf_wr.data;
        `OAG_SEL_IR0: index_reg_zero         <= rf_wr.data;
        `OAG_SEL_IR1: index_reg_one          <= rf_wr.data;
        `OAG_SEL_BK:  buffer_length_register <= rf_wr.data;
        default: ;
      endcase
    end
  end

  // registered outputs, one result per request
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_valid    <= 1'b0;
      data_addr     <= 24'h000000;
      mode_reserved <= 1'b0;
      wb            <= '0;
    end else begin
      addr_valid    <= req_valid;
      data_addr     <= req_valid ? next_addr : data_addr;
      mode_reserved <= req_valid && !req.direct && rsvd;
      wb.valid      <= do_wb;
      wb.sel        <= do_wb ? psel : wb.sel;
      wb.data       <= do_wb ? next_ptr : wb.data;
    end
  end

  // checks on the registered results
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // request classes seen by the checks
  logic q_ind;
  logic q_idx;
  logic q_hit;

  assign q_ind = req_valid && !req.direct;
  assign q_idx = q_ind && (grp == `OAG_GRP_IR0 || grp == `OAG_GRP_IR1);
  assign q_hit = rf_wr.en && (rf_wr.sel == {2'h0, psel});

  direct_addr_a: assert property (
    req_valid && req.direct |=>
      data_addr == {$past(data_page_pointer[7:0]),
                    $past(req.instr[15:0])})
    else $error("direct address is not page over constant");

  plain_mode_a: assert property (
    q_ind && plain |=> data_addr == $past(ptr_lo) && !wb.valid)
    else $error("plain indirect mode altered address or pointer");

  pre_disp_a: assert property (
    q_ind && grp == `OAG_GRP_DISP && pre |=>
      data_addr == $past(lin_sum))
    else $error("predisplacement address wrong");

  pre_wb_a: assert property (
    q_ind && !spec && kind == `OAG_KIND_PREWB |=>
      wb.valid && wb.data[23:0] == data_addr)
    else $error("pre-modify write-back differs from address");

  post_addr_a: assert property (
    q_ind && !spec && !pre |=>
      data_addr == $past(ptr_lo) && wb.valid)
    else $error("post mode did not address unmodified pointer");

  implied_one_a: assert property (
    q_ind && mode == 5'h04 && !req.disp_given |=>
      wb.data[23:0] == 24'($past(ptr_lo) + 24'h000001))
    else $error("implied displacement is not one");

  upper_keep_a: assert property (
    do_wb |=> wb.data[31:24] == $past(ptr_cur[31:24]))
    else $error("upper pointer byte changed on write-back");

  index_full_a: assert property (
    q_idx && mode[2:0] == 3'h0 |=>
      data_addr == 24'($past(ptr_lo) + $past(step)))
    else $error("index offset not applied in full");

  ptr_store_a: assert property (
    do_wb && !q_hit |=> ptr_reg[wb.sel] == wb.data)
    else $error("pointer register not updated by write-back");

  no_stall_a: assert property (
    req_valid [*3] |=>
      addr_valid && $past(addr_valid) && $past(addr_valid, 2))
    else $error("address unit stalled on back to back requests");

  circ_keep_a: assert property (
    q_ind && !spec && kind == `OAG_KIND_CIRC &&
    buffer_length_register[23:0] != 24'h000000 |=>
      (wb.data[23:0] & ~$past(oag_pkg::oag_smear(
         buffer_length_register[23:0]))) ==
      ($past(ptr_lo) & ~$past(oag_pkg::oag_smear(
         buffer_length_register[23:0]))))
    else $error("circular modify left the buffer");

  reserved_a: assert property (
    q_ind && rsvd |=> mode_reserved && !wb.valid)
    else $error("reserved mode not flagged");

  // strobes, holds, per-mode results and register loads
  addr_pulse_a: assert property (
    req_valid |=> addr_valid)
    else $error("no address one cycle after request");

  idle_quiet_a: assert property (
    !req_valid |=> !addr_valid && !wb.valid && !mode_reserved)
    else $error("result strobe without request");

  addr_hold_a: assert property (
    !req_valid |=> $stable(data_addr))
    else $error("operand address moved without request");

  wb_hold_a: assert property (
    !do_wb |=> $stable(wb.data) && $stable(wb.sel))
    else $error("write-back value moved without write-back");

  pre_sub_a: assert property (
    q_ind && grp == `OAG_GRP_DISP && pre && sub |=>
      data_addr == 24'($past(ptr_lo) - $past(disp_step)))
    else $error("predisplacement subtract address wrong");

  pre_nowb_a: assert property (
    q_ind && !spec && kind == `OAG_KIND_PRE |=> !wb.valid)
    else $error("pre mode without modify wrote back");

  post_add_a: assert property (
    q_ind && grp == `OAG_GRP_DISP && kind == `OAG_KIND_POST && !sub |=>
      wb.data[23:0] == 24'($past(ptr_lo) + $past(disp_step)))
    else $error("postdisplacement add update wrong");

  post_sub_a: assert property (
    q_ind && grp == `OAG_GRP_DISP && kind == `OAG_KIND_POST && sub |=>
      wb.data[23:0] == 24'($past(ptr_lo) - $past(disp_step)))
    else $error("postdisplacement subtract update wrong");

  circ_disp_a: assert property (
    q_ind && grp == `OAG_GRP_DISP && kind == `OAG_KIND_CIRC |=>
      data_addr == $past(ptr_lo) && wb.data[23:0] == $past(circ_sum))
    else $error("postdisplacement circular modify wrong");

  pre_ir0_a: assert property (
    q_ind && grp == `OAG_GRP_IR0 && pre |=>
      data_addr == oag_pkg::oag_addsub($past(ptr_lo),
                     $past(index_reg_zero[23:0]), $past(sub)))
    else $error("preindex zero address wrong");

  post_ir0_a: assert property (
    q_ind && grp == `OAG_GRP_IR0 && kind == `OAG_KIND_POST |=>
      data_addr == $past(ptr_lo) &&
      wb.data[23:0] == oag_pkg::oag_addsub($past(ptr_lo),
                         $past(index_reg_zero[23:0]), $past(sub)))
    else $error("postindex zero update wrong");

  circ_ir0_a: assert property (
    q_ind && grp == `OAG_GRP_IR0 && kind == `OAG_KIND_CIRC |=>
      data_addr == $past(ptr_lo) && wb.data[23:0] == $past(circ_sum))
    else $error("postindex zero circular modify wrong");

  pre_ir1_a: assert property (
    q_ind && grp == `OAG_GRP_IR1 && pre |=>
      data_addr == oag_pkg::oag_addsub($past(ptr_lo),
                     $past(index_reg_one[23:0]), $past(sub)))
    else $error("preindex one address wrong");

  post_ir1_a: assert property (
    q_ind && grp == `OAG_GRP_IR1 && kind == `OAG_KIND_POST |=>
      data_addr == $past(ptr_lo) &&
      wb.data[23:0] == oag_pkg::oag_addsub($past(ptr_lo),
                         $past(index_reg_one[23:0]), $past(sub)))
    else $error("postindex one update wrong");

  circ_ir1_a: assert property (
    q_ind && grp == `OAG_GRP_IR1 && kind == `OAG_KIND_CIRC |=>
      data_addr == $past(ptr_lo) && wb.data[23:0] == $past(circ_sum))
    else $error("postindex one circular modify wrong");

  wb_sel_a: assert property (
    do_wb |=> wb.sel == $past(req.instr[`OAG_PSEL_MSB:`OAG_PSEL_LSB]))
    else $error("write-back names the wrong pointer");

  reserved_addr_a: assert property (
    q_ind && rsvd |=> data_addr == $past(ptr_lo))
    else $error("reserved mode address is not the pointer");

  direct_quiet_a: assert property (
    req_valid && req.direct |=> !wb.valid && !mode_reserved)
    else $error("direct request touched a pointer");

  ptr_load_a: assert property (
    rf_wr.en && rf_wr.sel[4:3] == 2'h0 |=>
      ptr_reg[$past(rf_wr.sel[2:0])] == $past(rf_wr.data))
    else $error("pointer register load lost");

  page_load_a: assert property (
    rf_wr.en && rf_wr.sel == `OAG_SEL_DP |=>
      data_page_pointer == $past(rf_wr.data))
    else $error("page register load lost");

  index_load_a: assert property (
    rf_wr.en && rf_wr.sel == `OAG_SEL_IR1 |=>
      index_reg_one == $past(rf_wr.data))
    else $error("index one load lost");

  // main scenarios
  circ_wrap_c: cover property (
    q_ind && kind == `OAG_KIND_CIRC && !spec && circ_sum != lin_sum);
  idx_one_c: cover property (
    q_ind && grp == `OAG_GRP_IR1 ##1 q_ind && grp == `OAG_GRP_IR0);
  direct_c: cover property (req_valid && req.direct ##1 do_wb);
  burst_c: cover property (req_valid [*3]);
  reserved_c: cover property (q_ind && rsvd);

endmodule : oag_top
`default_nettype wire

// ==== tb/oag_dec_model.sv ====
// decoder-side model driving register writes and requests
`timescale 1ns/10ps
`default_nettype none
module oag_dec_model (
  // clock
  input  wire logic          core_clk,
  // toward the address unit
  output logic               req_valid,
  output oag_pkg::oag_req_t  req,
  output oag_pkg::oag_rf_wr_t rf_wr
);
  // idle values at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
    rf_wr = '0;
  end

  // one register write; data scrambled once released
  task automatic put_reg(input logic [4:0] sel, input logic [31:0] d);
    @(negedge core_clk);
    rf_wr = '{en: 1'b1, sel: sel, data: d};
    @(negedge core_clk);
    rf_wr = '{en: 1'b0, sel: ~sel, data: ~d};
  endtask : put_reg

  // one instruction; returns as the answer stands
  task automatic issue(input logic dir, input logic g, input logic [31:0] w);
    @(negedge core_clk);
    req = '{direct: dir, disp_given: g, instr: w};
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    req = '{direct: ~dir, disp_given: ~g, instr: ~w};
  endtask : issue

  // n indirect requests back to back; returns as the last answer stands
  task automatic issue_run(input int n, input logic g, input logic [31:0] w);
    @(negedge core_clk);
    req = '{direct: 1'b0, disp_given: g, instr: w};
    req_valid = 1'b1;
    repeat (n) @(negedge core_clk);
    req_valid = 1'b0;
    req = '{direct: 1'b1, disp_given: ~g, instr: ~w};
  endtask : issue_run
endmodule : oag_dec_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the operand address generator
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic                core_clk;
  logic                reset_n;
  logic                req_valid;
  oag_pkg::oag_req_t   req;
  oag_pkg::oag_rf_wr_t rf_wr;
  logic                addr_valid;
  logic [23:0]         data_addr;
  logic                mode_reserved;
  oag_pkg::oag_wb_t    wb;
  logic [31:0]         ar [8];
  logic [31:0]         ir0;
  logic [31:0]         ir1;
  logic [23:0]         bk;
  int                  num_errors;
  int                  samples_checked;

  oag_dec_model dec (.core_clk(core_clk), .req_valid(req_valid),
                     .req(req), .rf_wr(rf_wr));
  oag_top dut (.core_clk(core_clk), .reset_n(reset_n),
               .req_valid(req_valid), .req(req), .rf_wr(rf_wr),
               .addr_valid(addr_valid), .data_addr(data_addr),
               .mode_reserved(mode_reserved), .wb(wb));

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // expected wrap inside an aligned buffer of length l
  function automatic logic [23:0] circ(input logic [23:0] p, s, l,
                                       input logic sb);
    logic [23:0] m;
    logic [23:0] i;
    m = l;
    for (int k = 1; k < 24; k = k * 2) m = m | (m >> k);
    i = p & m;
    if (l == 24'h0) return sb ? p - s : p + s;
    if (sb) i = (i < s) ? i + l - s : i - s;
    else i = (i + s >= l) ? i + s - l : i + s;
    return (p & ~m) | i;
  endfunction : circ

  // one indirect request with its expected answer
  task automatic ind(input logic [4:0] m, input logic [2:0] p);
    logic        g;
    logic        wbe;
    logic [23:0] off;
    logic [23:0] sum;
    logic [23:0] nv;
    g = !m[2];
    off = (m[4:3] == 2'h1) ? ir0[23:0] :
          (m[4:3] == 2'h2) ? ir1[23:0] : (g ? 24'hC3 : 24'h1);
    sum = m[0] ? ar[p][23:0] - off : ar[p][23:0] + off;
    nv = (m[2:1] == 2'h3) ? circ(ar[p][23:0], off, bk, m[0]) : sum;
    wbe = (m[4:3] != 2'h3) && (m[2:1] != 2'h0);
    dec.issue(1'b0, g, {16'hFFFF, m, p, 8'hC3});
    chk(addr_valid, 32'h1);
    chk(data_addr, (m[4:3] == 2'h3 || m[2]) ? ar[p][23:0] : sum);
    chk(wb.valid, wbe);
    chk(mode_reserved, m > 5'h18);
    if (wbe) begin
      chk(wb.sel, p);
      chk(wb.data, {ar[p][31:24], nv});
      ar[p] = {ar[p][31:24], nv};
    end
  endtask : ind

  // clock at 50 MHz
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // hang guard
  initial begin
    #50us;
    num_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    num_errors = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    ir0 = 32'hAB00_0005;
    ir1 = 32'h5A00_000B;
    bk = 24'h10;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    chk(addr_valid, 32'h0);
    chk(data_addr, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      ar[k] = {8'hC0 | 8'(k), 24'hFFFFEF};
      dec.put_reg(5'(k), ar[k]);
    end
    dec.put_reg(5'h08, 32'hFFFF_FF5A);
    dec.put_reg(5'h09, ir0);
    dec.put_reg(5'h0A, ir1);
    dec.put_reg(5'h0B, {8'hFF, bk});
    dec.issue(1'b1, 1'b1, 32'hFFFF_1234);
    chk(data_addr, 32'h5A_1234);
    chk(wb.valid, 32'h0);
    $display("test direct done");
    for (int m = 0; m < 32; m++) ind(5'(m), 3'(m));
    $display("test all modes done");
    ir1 = 32'hFF12_3456;
    dec.put_reg(5'h0A, ir1);
    ind(5'h10, 3'h1);
    ind(5'h13, 3'h2);
    $display("test wide index done");
    dec.issue_run(3, 1'b1, {16'h0000, 5'h04, 3'h3, 8'h05});
    chk(addr_valid, 32'h1);
    chk(data_addr, 24'(ar[3][23:0] + 24'h00000A));
    chk(wb.data, {ar[3][31:24], 24'(ar[3][23:0] + 24'h00000F)});
    ar[3] = {ar[3][31:24], 24'(ar[3][23:0] + 24'h00000F)};
    ind(5'h18, 3'h3);
    $display("test back to back done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
